// [hdl/edcfu_core.sv]
// Ten channel-access units with their central access arbiter.
// Assumes queue, protocol and register master logic on mclk_in.
module edcfu_core
	import edcfu_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire logic [9:0] queue_ready_in,
	input wire logic channel_busy_in,
	output logic fetch_start_out,
	output logic [3:0] fetch_queue_out,
	input wire logic desc_valid_in,
	input wire edcfu_desc_s desc_in,
	input wire logic beat_valid_in,
	input wire edcfu_beat_s beat_in,
	output logic tx_valid_out,
	output edcfu_beat_s tx_beat_out,
	output edcfu_hdr_s tx_hdr_out,
	output logic tx_start_out,
	input wire logic result_valid_in,
	input wire edcfu_result_s result_in,
	output logic done_valid_out,
	output edcfu_done_s done_out,
	output logic halt_notice_out
);
	logic [9:0] qmask_r [NUM_UNITS];
	logic [7:0] min_contention_window_r [NUM_UNITS];
	logic [7:0] arbitration_spacing_r [NUM_UNITS];
	logic [7:0] thr_r [NUM_UNITS];
	logic [9:0] cw_r [NUM_UNITS];
	logic [9:0] boff_r [NUM_UNITS];
	logic [5:0] frame_rts_fail_limit_r [NUM_UNITS];
	logic [5:0] station_rts_fail_limit_r [NUM_UNITS];
	logic [5:0] station_data_fail_limit_r [NUM_UNITS];
	logic [5:0] strts_r [NUM_UNITS];
	logic [5:0] stdat_r [NUM_UNITS];
	logic [3:0] srl_r [NUM_UNITS];
	logic [3:0] lrl_r [NUM_UNITS];
	logic [3:0] rr_r [NUM_UNITS];
	logic [11:0] seq_r [NUM_UNITS];
	logic [19:0] bdur_r [NUM_UNITS];
	logic [63:0] blk_r [NUM_UNITS];
	logic [NUM_UNITS-1:0] persist_r;
	logic [NUM_UNITS-1:0] burst_en_r;
	logic [NUM_UNITS-1:0] halt_en_r;
	logic [NUM_UNITS-1:0] armed_r;
	logic [NUM_UNITS-1:0] halted_r;
	logic [NUM_UNITS-1:0] stlim_r;
	logic [NUM_UNITS-1:0] pend_w;
	logic [NUM_UNITS-1:0] req_w;
	logic [NUM_UNITS-1:0] met_w;
	logic [NUM_UNITS-1:0] draw_w;
	edcfu_state_e st_r;
	logic [3:0] cur_u_r;
	logic [3:0] cur_q_r;
	logic [3:0] retries_r;
	logic [5:0] frts_r;
	logic kv_r;
	logic [5:0] kidx_r;
	logic burst_r;
	logic [19:0] btimer_r;
	logic [11:0] idle_cyc_r;
	logic sifs_done_r;
	logic [8:0] idle_slots_r;
	logic [7:0] us_cnt_r;
	logic [15:0] lfsr_r;
	logic [31:0] rd_w;

	wire [3:0] w_unit = reg_addr_in[7:4];
	wire [3:0] w_reg = reg_addr_in[3:0];
	wire w_hit = w_unit < 4'(NUM_UNITS);
	wire w_wr = reg_wr_in && w_hit;
	wire slot_tick_w = !channel_busy_in && sifs_done_r && idle_cyc_r == 12'(SLOT_CYC - 1);
	wire us_tick_w = us_cnt_r == 8'(USEC_CYC - 1);
	wire own_w = st_r != S_IDLE;
	wire [3:0] win_w = edcfu_hi(req_w);
	wire hold_w = burst_r && btimer_r != 20'h0 && pend_w[cur_u_r] && !halted_r[cur_u_r];
	wire [3:0] gnt_u_w = burst_r ? cur_u_r : win_w;
	wire gnt_w = st_r == S_IDLE && (burst_r ? hold_w : |req_w);
	wire [3:0] pick_w = edcfu_rr(queue_ready_in & qmask_r[gnt_u_w], rr_r[gnt_u_w]);
	wire blk_hit_w = desc_in.key_valid && blk_r[cur_u_r][desc_in.key_index];
	wire discard_w = blk_hit_w && !desc_in.unblock;
	wire take_desc_w = st_r == S_DESC && desc_valid_in;
	wire res_w = st_r == S_RES && result_valid_in;
	wire fail_w = res_w && !result_in.ok;
	wire [3:0] lim_w = result_in.long_frame ? lrl_r[cur_u_r] : srl_r[cur_u_r];
	wire rts_out_w = result_in.rts_fail && frts_r + 6'h1 >= frame_rts_fail_limit_r[cur_u_r];
	wire last_try_w = fail_w && (retries_r + 4'h1 >= lim_w || rts_out_w);
	wire drop_end_w = st_r == S_DROP && beat_valid_in && beat_in.last;
	wire done_w = (res_w && (result_in.ok || last_try_w)) || drop_end_w;
	wire ok_w = res_w && result_in.ok;
	wire start_w = st_r == S_WAIT && boff_r[cur_u_r] == 10'h0 && met_w[cur_u_r]
		&& !channel_busy_in;
	wire [9:0] cw_up_w = cw_r[cur_u_r][9] ? 10'h3ff : {cw_r[cur_u_r][8:0], 1'b1};
	wire [9:0] cw_new_w = persist_r[cur_u_r] ? cw_up_w : cw_r[cur_u_r];

	always_comb begin
		for (int u = 0; u < NUM_UNITS; u++) begin
			pend_w[u] = |(queue_ready_in & qmask_r[u]);
			met_w[u] = sifs_done_r && idle_slots_r >= {1'b0, arbitration_spacing_r[u]};
			req_w[u] = pend_w[u] && !halted_r[u] && boff_r[u] <= {2'b00, thr_r[u]};
			draw_w[u] = pend_w[u] && channel_busy_in && !armed_r[u]
				&& !(own_w && cur_u_r == 4'(u));
		end
	end

	always_comb begin
		rd_w = 32'h0;
		if (w_hit) begin
			case (w_reg)
				REG_CFG0: rd_w = {13'h0, halt_en_r[w_unit], burst_en_r[w_unit],
					persist_r[w_unit], 6'h0, qmask_r[w_unit]};
				REG_CFG1: rd_w = {8'h0, thr_r[w_unit], arbitration_spacing_r[w_unit], min_contention_window_r[w_unit]};
				REG_LIMIT: rd_w = {6'h0, lrl_r[w_unit], srl_r[w_unit], station_data_fail_limit_r[w_unit],
					station_rts_fail_limit_r[w_unit], frame_rts_fail_limit_r[w_unit]};
				REG_SEQ: rd_w = {20'h0, seq_r[w_unit]};
				REG_BURST: rd_w = {12'h0, bdur_r[w_unit]};
				REG_STATUS: rd_w = {6'h0, boff_r[w_unit], 11'h0, armed_r[w_unit],
					burst_r && cur_u_r == w_unit, own_w && cur_u_r == w_unit,
					stlim_r[w_unit], halted_r[w_unit]};
				REG_BLK_LO: rd_w = blk_r[w_unit][31:0];
				REG_BLK_HI: rd_w = blk_r[w_unit][63:32];
				default: rd_w = 32'h0;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			reg_rdata_out <= 32'h0;
			lfsr_r <= LFSR_RST;
			us_cnt_r <= 8'h0;
		end else begin
			reg_rdata_out <= reg_rd_in ? rd_w : 32'h0;
			lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
			us_cnt_r <= us_tick_w ? 8'h0 : us_cnt_r + 8'h1;
		end
	end

	// Channel idle time: SIFS first, then whole slots.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			idle_cyc_r <= 12'h0;
			sifs_done_r <= 1'b0;
			idle_slots_r <= 9'h0;
		end else if (channel_busy_in) begin
			idle_cyc_r <= 12'h0;
			sifs_done_r <= 1'b0;
			idle_slots_r <= 9'h0;
		end else if (!sifs_done_r) begin
			sifs_done_r <= idle_cyc_r == 12'(SIFS_CYC - 1);
			idle_cyc_r <= idle_cyc_r == 12'(SIFS_CYC - 1) ? 12'h0 : idle_cyc_r + 12'h1;
		end else if (slot_tick_w) begin
			idle_cyc_r <= 12'h0;
			if (idle_slots_r != 9'h1ff) idle_slots_r <= idle_slots_r + 9'h1;
		end else begin
			idle_cyc_r <= idle_cyc_r + 12'h1;
		end
	end

	// Per-unit state for all ten units.
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				qmask_r[u] <= 10'h0;
				min_contention_window_r[u] <= MIN_CONTENTION_WINDOW_RST;
				arbitration_spacing_r[u] <= ARBITRATION_SPACING_RST;
				thr_r[u] <= THR_RST;
				cw_r[u] <= {2'b00, MIN_CONTENTION_WINDOW_RST};
				boff_r[u] <= 10'h0;
				frame_rts_fail_limit_r[u] <= FAIL_LIM_RST;
				station_rts_fail_limit_r[u] <= FAIL_LIM_RST;
				station_data_fail_limit_r[u] <= FAIL_LIM_RST;
				strts_r[u] <= 6'h0;
				stdat_r[u] <= 6'h0;
				srl_r[u] <= SRL_RST;
				lrl_r[u] <= LRL_RST;
				rr_r[u] <= 4'h0;
				seq_r[u] <= 12'h0;
				bdur_r[u] <= 20'h0;
				blk_r[u] <= 64'h0;
			end
			persist_r <= '0;
			burst_en_r <= '0;
			halt_en_r <= '0;
			armed_r <= '0;
			halted_r <= '0;
			stlim_r <= '0;
		end else begin
			for (int u = 0; u < NUM_UNITS; u++) begin
				if (draw_w[u]) begin
					boff_r[u] <= lfsr_r[9:0] & cw_r[u];
					armed_r[u] <= 1'b1;
				end else if (armed_r[u] && slot_tick_w && boff_r[u] != 10'h0 && met_w[u]) begin
					boff_r[u] <= boff_r[u] - 10'h1;
				end
				if (gnt_w && gnt_u_w == 4'(u)) begin
					rr_r[u] <= pick_w == 4'h9 ? 4'h0 : pick_w + 4'h1;
				end
				if (start_w && cur_u_r == 4'(u)) armed_r[u] <= 1'b0;
				if (take_desc_w && cur_u_r == 4'(u) && blk_hit_w && desc_in.unblock) begin
					blk_r[u][desc_in.key_index] <= 1'b0;
				end
				if (w_wr && w_unit == 4'(u)) begin
					case (w_reg)
						REG_CFG0: begin
							qmask_r[u] <= reg_wdata_in[9:0];
							persist_r[u] <= reg_wdata_in[CFG0_PERSIST_BIT];
							burst_en_r[u] <= reg_wdata_in[CFG0_BURST_BIT];
							halt_en_r[u] <= reg_wdata_in[CFG0_HALT_BIT];
						end
						REG_CFG1: begin
							min_contention_window_r[u] <= reg_wdata_in[7:0];
							cw_r[u] <= {2'b00, reg_wdata_in[7:0]};
							arbitration_spacing_r[u] <= reg_wdata_in[CFG1_ARBITRATION_SPACING_LSB +: 8];
							thr_r[u] <= reg_wdata_in[CFG1_THR_LSB +: 8];
						end
						REG_LIMIT: begin
							frame_rts_fail_limit_r[u] <= reg_wdata_in[5:0];
							station_rts_fail_limit_r[u] <= reg_wdata_in[LIM_STATION_RTS_FAIL_LIMIT_LSB +: 6];
							station_data_fail_limit_r[u] <= reg_wdata_in[LIM_STATION_DATA_FAIL_LIMIT_LSB +: 6];
							srl_r[u] <= reg_wdata_in[LIM_SRL_LSB +: 4];
							lrl_r[u] <= reg_wdata_in[LIM_LRL_LSB +: 4];
						end
						REG_SEQ: seq_r[u] <= reg_wdata_in[11:0];
						REG_BURST: bdur_r[u] <= reg_wdata_in[19:0];
						REG_STATUS: begin
							if (reg_wdata_in[STAT_RESUME_BIT]) halted_r[u] <= 1'b0;
							if (reg_wdata_in[STAT_STLIM_BIT]) stlim_r[u] <= 1'b0;
						end
						REG_BLK_CMD: blk_r[u][reg_wdata_in[5:0]] <= reg_wdata_in[BLK_VAL_BIT];
						default: ;
					endcase
				end
				if (fail_w && cur_u_r == 4'(u)) begin
					// Back off again for the same frame.
					cw_r[u] <= cw_new_w;
					boff_r[u] <= lfsr_r[9:0] & cw_new_w;
					armed_r[u] <= 1'b1;
					if (kv_r) blk_r[u][kidx_r] <= 1'b1;
					if (halt_en_r[u]) halted_r[u] <= 1'b1;
					if (result_in.rts_fail) begin
						strts_r[u] <= strts_r[u] + 6'h1;
						if (strts_r[u] + 6'h1 >= station_rts_fail_limit_r[u]) stlim_r[u] <= 1'b1;
					end else begin
						stdat_r[u] <= stdat_r[u] + 6'h1;
						if (stdat_r[u] + 6'h1 >= station_data_fail_limit_r[u]) stlim_r[u] <= 1'b1;
					end
				end
				if (done_w && cur_u_r == 4'(u) && st_r == S_RES) cw_r[u] <= {2'b00, min_contention_window_r[u]};
				if (ok_w && cur_u_r == 4'(u)) begin
					strts_r[u] <= 6'h0;
					stdat_r[u] <= 6'h0;
					seq_r[u] <= seq_r[u] + 12'h1;
				end
			end
		end
	end

	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st_r <= S_IDLE;
			cur_u_r <= 4'h0;
			cur_q_r <= 4'h0;
			retries_r <= 4'h0;
			frts_r <= 6'h0;
			kv_r <= 1'b0;
			kidx_r <= 6'h0;
			burst_r <= 1'b0;
			btimer_r <= 20'h0;
			fetch_start_out <= 1'b0;
			fetch_queue_out <= 4'h0;
			tx_valid_out <= 1'b0;
			tx_beat_out <= '0;
			tx_hdr_out <= '0;
			tx_start_out <= 1'b0;
			done_valid_out <= 1'b0;
			done_out <= '0;
			halt_notice_out <= 1'b0;
		end else begin
			fetch_start_out <= 1'b0;
			tx_valid_out <= 1'b0;
			tx_start_out <= 1'b0;
			done_valid_out <= 1'b0;
			halt_notice_out <= |halted_r;
			if (burst_r && us_tick_w && btimer_r != 20'h0) btimer_r <= btimer_r - 20'h1;
			unique case (st_r)
				S_IDLE: begin
					if (burst_r && !hold_w) burst_r <= 1'b0;
					if (gnt_w) begin
						cur_u_r <= gnt_u_w;
						cur_q_r <= pick_w;
						fetch_start_out <= 1'b1;
						fetch_queue_out <= pick_w;
						retries_r <= 4'h0;
						frts_r <= 6'h0;
						st_r <= S_DESC;
						// Burst timer starts at first grant.
						if (!burst_r && burst_en_r[gnt_u_w]) begin
							burst_r <= 1'b1;
							btimer_r <= bdur_r[gnt_u_w];
						end
					end
				end
				S_DESC: begin
					if (desc_valid_in) begin
						kv_r <= desc_in.key_valid;
						kidx_r <= desc_in.key_index;
						tx_hdr_out <= {cur_u_r, cur_q_r, desc_in.ctl2, desc_in.ctl3, seq_r[cur_u_r]};
						st_r <= discard_w ? S_DROP : S_FWD;
					end
				end
				S_FWD: begin
					if (beat_valid_in) begin
						tx_valid_out <= 1'b1;
						tx_beat_out <= beat_in;
						if (beat_in.last) st_r <= S_WAIT;
					end
				end
				S_DROP: begin
					if (drop_end_w) st_r <= S_IDLE;
				end
				S_WAIT: begin
					if (start_w) begin
						tx_start_out <= 1'b1;
						st_r <= S_RES;
					end
				end
				S_RES: begin
					if (done_w) begin
						st_r <= S_IDLE;
					end else if (res_w) begin
						retries_r <= retries_r + 4'h1;
						if (result_in.rts_fail) frts_r <= frts_r + 6'h1;
						st_r <= S_WAIT;
					end
				end
			endcase
			if (done_w) begin
				done_valid_out <= 1'b1;
				done_out <= {cur_u_r, cur_q_r, ok_w, st_r == S_DROP, retries_r};
			end
		end
	end

	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	property p_prio_top;
		(st_r == S_IDLE && !burst_r && req_w[9]) |=> cur_u_r == 4'h9;
	endproperty
	a_prio_top: assert property (p_prio_top) else $error("unit 9 not granted");
	property p_winner;
		(st_r == S_IDLE && !burst_r && |req_w) |=> ($past(req_w) >> cur_u_r) == 10'h1;
	endproperty
	a_winner: assert property (p_winner) else $error("grant not highest");
	property p_mask;
		fetch_start_out |-> qmask_r[cur_u_r][fetch_queue_out] && st_r == S_DESC;
	endproperty
	a_mask: assert property (p_mask) else $error("fetch from unassociated queue");
	property p_start;
		tx_start_out |-> $past(met_w[cur_u_r]) && !$past(channel_busy_in) && st_r == S_RES;
	endproperty
	a_start: assert property (p_start) else $error("start before access rules met");
	property p_imm;
		fetch_start_out && !$past(burst_r) |-> $past(boff_r[gnt_u_w] <= {2'b00, thr_r[gnt_u_w]});
	endproperty
	a_imm: assert property (p_imm) else $error("request above threshold");
	property p_burst_hold;
		burst_r && $past(burst_r) |-> $stable(cur_u_r);
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("burst lost grant");
	property p_drop;
		(take_desc_w && blk_hit_w && !desc_in.unblock) |=> st_r == S_DROP ##[1:1000] 1'b1;
	endproperty
	a_drop: assert property (p_drop) else $error("blocked frame not dropped");
	property p_block;
		(fail_w && kv_r) |=> blk_r[cur_u_r][kidx_r];
	endproperty
	a_block: assert property (p_block) else $error("blocking bit not set");
	property p_halt;
		(fail_w && halt_en_r[cur_u_r]) |=> halted_r[cur_u_r] ##1 halt_notice_out;
	endproperty
	a_halt: assert property (p_halt) else $error("failure did not halt");
	property p_done;
		done_valid_out |-> $past(st_r == S_RES || st_r == S_DROP) && st_r == S_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("completion out of place");
	c_burst: cover property (burst_r && fetch_start_out && $past(burst_r));
	c_drop: cover property (done_valid_out && done_out.discarded);
	c_retry: cover property (fail_w && !last_try_w);
	c_ok: cover property (done_valid_out && done_out.ok);
endmodule

// [hdl/edcfu_pkg.sv]
// Constants, types and helpers for the channel-access unit block.
// Assumes one 250 MHz core clock shared with queue and protocol logic.
// Function
// - Access priority is fixed: unit 9 first, then 8, then 7 down to 0.
// - Ten units; 0 to 7 for priority levels, 8 and 9 for beacon traffic.
// - Ready bits of the ten queues are ANDed with each unit's association mask.
// - A unit with ready queues waits out ARBITRATION_SPACING, or draws backoff if busy.
// - Contention window counts slots; ARBITRATION_SPACING counts slots beyond SIFS.
// - Persistence 0 keeps the window; 1 doubles it on failure.
// - Request the arbiter once backoff is at or below the software threshold.
// - The arbiter grants the highest-priority requesting unit.
// - A granted unit picks a queue round-robin and starts its fetch.
// - Frame data go out with descriptor words 2 and 3 and a tag.
// - Air transmission starts only at zero backoff with ARBITRATION_SPACING met.
// - Success selects a new frame; failure backs off and retries until limits.
// - A finished frame produces a status write-back.
// - Six-bit failure limits are honoured; a 12-bit sequence number is kept.
// - Bursting loads a microsecond timer at the first grant.
// - During a burst the arbiter keeps granting the bursting unit.
// - A burst ends on timer expiry or no ready queue, at frame boundaries.
// - Each unit holds 64 blocking bits, cleared at reset.
// - Blocked frames are dropped unless unblock is set, which clears the bit.
// - A failed frame sets its destination blocking bit.
// - Optional halt on failure until host resumes; host unblocks only reissues.
package edcfu_pkg;
	localparam int NUM_UNITS = 10;
	localparam logic [3:0] REG_CFG0 = 4'h0;
	localparam logic [3:0] REG_CFG1 = 4'h1;
	localparam logic [3:0] REG_LIMIT = 4'h2;
	localparam logic [3:0] REG_SEQ = 4'h3;
	localparam logic [3:0] REG_BURST = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h5;
	localparam logic [3:0] REG_BLK_CMD = 4'h6;
	localparam logic [3:0] REG_BLK_LO = 4'h7;
	localparam logic [3:0] REG_BLK_HI = 4'h8;
	localparam int CFG0_PERSIST_BIT = 16;
	localparam int CFG0_BURST_BIT = 17;
	localparam int CFG0_HALT_BIT = 18;
	localparam int CFG1_ARBITRATION_SPACING_LSB = 8;
	localparam int CFG1_THR_LSB = 16;
	localparam int LIM_STATION_RTS_FAIL_LIMIT_LSB = 6;
	localparam int LIM_STATION_DATA_FAIL_LIMIT_LSB = 12;
	localparam int LIM_SRL_LSB = 18;
	localparam int LIM_LRL_LSB = 22;
	localparam int STAT_RESUME_BIT = 0;
	localparam int STAT_STLIM_BIT = 1;
	localparam int STAT_ACTIVE_BIT = 2;
	localparam int STAT_BURST_BIT = 3;
	localparam int STAT_ARMED_BIT = 4;
	localparam int STAT_BOFF_LSB = 16;
	localparam int BLK_VAL_BIT = 8;
	localparam logic [7:0] MIN_CONTENTION_WINDOW_RST = 8'h0f;
	localparam logic [7:0] ARBITRATION_SPACING_RST = 8'h02;
	localparam logic [7:0] THR_RST = 8'h04;
	localparam logic [5:0] FAIL_LIM_RST = 6'h3f;
	localparam logic [3:0] SRL_RST = 4'h7;
	localparam logic [3:0] LRL_RST = 4'h4;
	localparam logic [15:0] LFSR_RST = 16'hace1;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLOT_TIME_NS = 9000;
	localparam int SIFS_TIME_NS = 16000;
	localparam int USEC_NS = 1000;
	localparam int SLOT_CYC = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SIFS_CYC = (SIFS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int USEC_CYC = USEC_NS / CLK_PERIOD_NS;
	typedef enum {S_IDLE, S_DESC, S_FWD, S_DROP, S_WAIT, S_RES} edcfu_state_e;
	typedef struct packed {
		logic key_valid;
		logic [5:0] key_index;
		logic unblock;
		logic [31:0] ctl2;
		logic [31:0] ctl3;
	} edcfu_desc_s;
	typedef struct packed {
		logic [31:0] data;
		logic last;
	} edcfu_beat_s;
	typedef struct packed {
		logic [3:0] unit;
		logic [3:0] queue;
	} edcfu_tag_s;
	typedef struct packed {
		edcfu_tag_s tag;
		logic [31:0] ctl2;
		logic [31:0] ctl3;
		logic [11:0] seq;
	} edcfu_hdr_s;
	typedef struct packed {
		logic ok;
		logic rts_fail;
		logic long_frame;
	} edcfu_result_s;
	typedef struct packed {
		edcfu_tag_s tag;
		logic ok;
		logic discarded;
		logic [3:0] retries;
	} edcfu_done_s;
	function automatic logic [3:0] edcfu_hi(input logic [9:0] v);
		edcfu_hi = 4'h0;
		for (int i = 0; i < 10; i++) begin
			if (v[i]) edcfu_hi = 4'(i);
		end
	endfunction
	function automatic logic [3:0] edcfu_rr(input logic [9:0] m, input logic [3:0] p);
		logic found;
		found = 1'b0;
		edcfu_rr = 4'h0;
		for (int i = 9; i >= 0; i--) begin
			if (m[i] && 4'(i) >= p) begin
				edcfu_rr = 4'(i);
				found = 1'b1;
			end
		end
		for (int i = 9; i >= 0; i--) begin
			if (m[i] && !found) edcfu_rr = 4'(i);
		end
	endfunction
endpackage

// [tb/edcfu_far_model.sv]
// Behavioural queue units and protocol unit facing the channel-access units.
// Assumes the units' core clock and reset; each queue holds one pending frame.
module edcfu_far_model
	import edcfu_pkg::*;
(
	input wire logic mclk_in,
	input wire logic resetn_in,
	input wire logic [9:0] load_in,
	input wire edcfu_desc_s desc_cfg_in,
	input wire logic [3:0] fails_in,
	input wire logic fetch_start_in,
	input wire logic [3:0] fetch_queue_in,
	input wire logic tx_start_in,
	output logic [9:0] queue_ready_out,
	output logic desc_valid_out,
	output edcfu_desc_s desc_out,
	output logic beat_valid_out,
	output edcfu_beat_s beat_out,
	output logic result_valid_out,
	output edcfu_result_s result_out
);
	logic beat_due_r;
	logic [3:0] fails_r;
	logic [9:0] fetch_bit;
	assign fetch_bit = fetch_start_in ? (10'h001 << fetch_queue_in) : 10'h000;
	always_ff @(posedge mclk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			queue_ready_out <= 10'h000;
			desc_valid_out <= 1'b0;
			desc_out <= '0;
			beat_valid_out <= 1'b0;
			beat_out <= '0;
			beat_due_r <= 1'b0;
			result_valid_out <= 1'b0;
			result_out <= '0;
			fails_r <= 4'h0;
		end else begin
			queue_ready_out <= (queue_ready_out | load_in) & ~fetch_bit;
			desc_valid_out <= fetch_start_in;
			beat_due_r <= fetch_start_in;
			beat_valid_out <= beat_due_r;
			result_valid_out <= tx_start_in;
			// Released lines toggle so a stale value never passes for data.
			desc_out <= fetch_start_in ? desc_cfg_in : ~desc_out;
			beat_out <= beat_due_r ? {28'hbea7000, fetch_queue_in, 1'b1} : ~beat_out;
			result_out <= tx_start_in ? {fails_r == 4'h0, 2'b00} : ~result_out;
			if (fetch_start_in) begin
				fails_r <= fails_in;
			end else if (tx_start_in && fails_r != 4'h0) begin
				fails_r <= fails_r - 4'h1;
			end
		end
	end
endmodule

// [tb/tb_edcf_channel_access_units.sv]
// Self-checking bench for the ten channel-access units and their arbiter.
// Assumes the far-side model answers fetches, beats and results promptly.
module tb_edcf_channel_access_units
	import edcfu_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] a;
		logic wr;
		logic [31:0] d;
		logic [31:0] e;
	} edcfu_row_s;
	edcfu_row_s rows [9] = '{
		'{8'h01, 1'b0, 32'h0, {8'h00, THR_RST, ARBITRATION_SPACING_RST, MIN_CONTENTION_WINDOW_RST}},
		'{8'h92, 1'b0, 32'h0, {6'h00, LRL_RST, SRL_RST, FAIL_LIM_RST, FAIL_LIM_RST, FAIL_LIM_RST}},
		'{8'h53, 1'b1, 32'hffffffff, 32'h00000fff},
		'{8'h54, 1'b1, 32'hffffffff, 32'h000fffff},
		'{8'ha1, 1'b1, 32'hffffffff, 32'h0},
		'{8'h00, 1'b0, 32'h0, 32'h0},
		'{8'h07, 1'b0, 32'h0, 32'h0},
		'{8'h16, 1'b1, 32'h0000013f, 32'h0},
		'{8'h18, 1'b0, 32'h0, 32'h80000000}};
	logic [3:0] pri [3] = '{4'h9, 4'h5, 4'h2};
	logic mclk_in, resetn_in, wr_stb, rd_stb, busy, fetch_start, desc_valid, beat_valid;
	logic tx_valid, tx_start, result_valid, done_valid, halt_notice;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd, seen_data;
	logic [9:0] queue_ready, load;
	logic [3:0] fetch_queue, fails;
	edcfu_desc_s desc, desc_cfg;
	edcfu_beat_s beat, tx_beat;
	edcfu_hdr_s tx_hdr;
	edcfu_result_s result;
	edcfu_done_s done;
	int error_cnt, n_compared, starts;
	time t0, t_start;
	edcfu_core edcfu_core_i (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
		.reg_wdata_in(reg_wdata), .reg_wr_in(wr_stb), .reg_rd_in(rd_stb),
		.reg_rdata_out(reg_rdata), .queue_ready_in(queue_ready), .channel_busy_in(busy),
		.fetch_start_out(fetch_start), .fetch_queue_out(fetch_queue),
		.desc_valid_in(desc_valid), .desc_in(desc), .beat_valid_in(beat_valid),
		.beat_in(beat), .tx_valid_out(tx_valid), .tx_beat_out(tx_beat),
		.tx_hdr_out(tx_hdr), .tx_start_out(tx_start), .result_valid_in(result_valid),
		.result_in(result), .done_valid_out(done_valid), .done_out(done),
		.halt_notice_out(halt_notice));
	edcfu_far_model edcfu_far_model_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
		.load_in(load), .desc_cfg_in(desc_cfg), .fails_in(fails),
		.fetch_start_in(fetch_start), .fetch_queue_in(fetch_queue), .tx_start_in(tx_start),
		.queue_ready_out(queue_ready), .desc_valid_out(desc_valid), .desc_out(desc),
		.beat_valid_out(beat_valid), .beat_out(beat), .result_valid_out(result_valid),
		.result_out(result));
	initial begin
		mclk_in = 1'b0;
		forever #2 mclk_in = ~mclk_in;
	end
	always @(negedge mclk_in) begin
		if (tx_valid === 1'b1) seen_data = tx_beat.data;
		if (tx_start === 1'b1) begin
			starts++;
			t_start = $time;
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("compared=%0d errors=%0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_addr <= a;
		reg_wdata <= d;
		wr_stb <= 1'b1;
		@(posedge mclk_in);
		wr_stb <= 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		reg_addr <= a;
		rd_stb <= 1'b1;
		@(posedge mclk_in);
		rd_stb <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic send(input logic [9:0] m);
		@(posedge mclk_in);
		load <= m;
		@(posedge mclk_in);
		load <= 10'h000;
	endtask
	task automatic frame(input logic [3:0] u, input logic [3:0] q, input logic ok,
		input logic disc, input int n);
		int k;
		starts = 0;
		for (k = 0; k < 30000; k++) begin
			@(negedge mclk_in);
			if (done_valid === 1'b1) break;
		end
		if (k == 30000) begin
			error_cnt++;
		end else begin
			check(32'(done.tag), 32'({u, q}));
			check(32'(fetch_queue), 32'(q));
			check(32'(done.discarded), 32'(disc));
			check(32'(starts), 32'(n));
			if (!disc) begin
				check(32'(done.ok), 32'(ok));
				check(32'(tx_hdr.tag), 32'({u, q}));
				check(tx_hdr.ctl2, desc_cfg.ctl2);
				check(seen_data, {28'hbea7000, q});
			end
		end
		@(posedge mclk_in);
	endtask
	initial begin
		repeat (90000) @(posedge mclk_in);
		error_cnt++;
		close_out();
	end
	initial begin
		resetn_in = 1'b0;
		{wr_stb, rd_stb, busy, reg_addr, reg_wdata, load, fails} = '0;
		desc_cfg = '{1'b0, 6'h00, 1'b0, 32'h2c2c0002, 32'h3c3c0003};
		error_cnt = 0;
		n_compared = 0;
		repeat (16) @(posedge mclk_in);
		resetn_in <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) reg_wr(rows[i].a, rows[i].d);
			reg_rd(rows[i].a, rd);
			check(rd, rows[i].e);
		end
		foreach (pri[i]) begin
			reg_wr({pri[i], REG_CFG1}, 32'h00040000);
			reg_wr({pri[i], REG_CFG0}, 32'(10'h001 << pri[i]));
		end
		send(10'h224);
		foreach (pri[i]) frame(pri[i], pri[i], 1'b1, 1'b0, 1);
		reg_wr(8'h01, 32'h00040000);
		reg_wr(8'h02, {6'h00, LRL_RST, 4'h2, FAIL_LIM_RST, FAIL_LIM_RST, FAIL_LIM_RST});
		reg_wr(8'h00, 32'h00000001);
		desc_cfg.key_valid <= 1'b1;
		desc_cfg.key_index <= 6'h05;
		fails <= 4'h2;
		send(10'h001);
		frame(4'h0, 4'h0, 1'b0, 1'b0, 2);
		reg_rd(8'h07, rd);
		check(rd, 32'h00000020);
		fails <= 4'h0;
		send(10'h001);
		frame(4'h0, 4'h0, 1'b0, 1'b1, 0);
		reg_rd(8'h07, rd);
		check(rd, 32'h00000020);
		desc_cfg.unblock <= 1'b1;
		send(10'h001);
		frame(4'h0, 4'h0, 1'b1, 1'b0, 1);
		reg_rd(8'h07, rd);
		check(rd, 32'h00000000);
		check(32'(halt_notice), 32'h0);
		reg_wr(8'h00, 32'h00040001);
		reg_wr(8'h02, {6'h00, LRL_RST, 4'h1, FAIL_LIM_RST, FAIL_LIM_RST, FAIL_LIM_RST});
		fails <= 4'h1;
		send(10'h001);
		frame(4'h0, 4'h0, 1'b0, 1'b0, 1);
		reg_rd(8'h05, rd);
		check(32'(rd[0]), 32'h1);
		check(32'(halt_notice), 32'h1);
		fails <= 4'h0;
		send(10'h001);
		repeat (8) @(posedge mclk_in);
		check(32'(queue_ready), 32'h001);
		reg_wr(8'h05, 32'h00000001);
		frame(4'h0, 4'h0, 1'b1, 1'b0, 1);
		check(32'(halt_notice), 32'h0);
		reg_wr(8'h24, 32'h0000000a);
		reg_wr(8'h20, 32'h0002000c);
		send(10'h00c);
		send(10'h020);
		frame(4'h2, 4'h3, 1'b1, 1'b0, 1);
		frame(4'h2, 4'h2, 1'b1, 1'b0, 1);
		frame(4'h5, 4'h5, 1'b1, 1'b0, 1);
		busy <= 1'b1;
		send(10'h200);
		repeat (8) @(posedge mclk_in);
		busy <= 1'b0;
		t0 = $time;
		frame(4'h9, 4'h9, 1'b1, 1'b0, 1);
		check(32'(t_start - t0 >= SIFS_CYC * CLK_PERIOD_NS), 32'h1);
		resetn_in <= 1'b0;
		repeat (2) @(posedge mclk_in);
		resetn_in <= 1'b1;
		reg_rd(8'h18, rd);
		check(rd, 32'h0);
		close_out();
	end
endmodule
